//--- homing_pkg.sv
// constants, register indices and carrier types of the homing sequencer
package homing_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ         = 200_000_000;
	localparam int TIMEOUT_UNIT_MS     = 10;
	localparam int TIMEOUT_UNIT_CYCLES = (CLK_FREQ_HZ / 1000) * TIMEOUT_UNIT_MS;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_CONTROL      = 16'h6040;
	localparam logic [15:0] IDX_STATUS       = 16'h6041;
	localparam logic [15:0] IDX_POS_FEEDBACK = 16'h6064;
	localparam logic [15:0] IDX_HOME_OFFSET  = 16'h607C;
	localparam logic [15:0] IDX_HOMING_MODE  = 16'h6098;
	localparam logic [15:0] IDX_CALC_SELECT  = 16'h60E6;
	localparam logic [15:0] IDX_TIMEOUT      = 16'h2013;
	localparam logic [15:0] IDX_HIGH_SPEED   = 16'h6200;
	localparam logic [15:0] IDX_LOW_SPEED    = 16'h6201;
	localparam logic [15:0] IDX_IRQ_STATUS   = 16'h6300;
	localparam logic [15:0] IDX_IRQ_MASK     = 16'h6301;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_START_BIT   = 4;
	localparam int STAT_SUCCESS_BIT = 12;
	localparam int STAT_ERROR_BIT   = 13;
	localparam int STAT_TIMEOUT_BIT = 14;
	localparam int IRQ_DONE_BIT     = 0;
	localparam int IRQ_ERROR_BIT    = 1;
	localparam int IRQ_TIMEOUT_BIT  = 2;
	localparam int IRQ_WIDTH        = 3;

	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [15:0] CONTROL_RESET     = 16'h0000;
	localparam logic [7:0]  CALC_SELECT_RESET = 8'h00;
	localparam logic [7:0]  HOMING_MODE_RESET = 8'h08;
	localparam logic [15:0] TIMEOUT_RESET     = 16'h0064;
	localparam logic [31:0] SPEED_RESET       = 32'h0000_0000;
	localparam logic [31:0] OFFSET_RESET      = 32'h0000_0000;
	localparam logic [7:0]  CALC_WITH_FEEDBACK = 8'h01;
	localparam logic [7:0]  METHOD_REV_FIRST   = 8'h08;
	localparam logic [7:0]  METHOD_FWD_FIRST   = 8'h09;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE        = 3'b000,
		ST_FAST        = 3'b001,
		ST_SLOW_FIRST  = 3'b010,
		ST_SLOW_SECOND = 3'b011,
		ST_WAIT_INDEX  = 3'b100,
		ST_LOAD        = 3'b101,
		ST_DONE        = 3'b110,
		ST_FAULT       = 3'b111
	} home_state_t;

	// sensor inputs, origin switch on the top bit
	typedef struct packed {
		logic origin;
		logic fwd_limit;
		logic index;
	} sense_t;

	// motion command toward the drive
	typedef struct packed {
		logic        run;
		logic        fwd;
		logic [31:0] speed;
	} motion_t;

endpackage

//--- edge_detect.sv
// rising and falling edge detector for a group of synchronous levels
`timescale 1ns/1ps
module edge_detect #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// levels and edges
	input  wire logic [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] prev;

	// previous sample of each level
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prev <= level; // no false edge when a level idles high
		end else begin
			prev <= level;
		end
	end

	// one edge per bit
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign rise[g] = level[g] & ~prev[g];
			assign fall[g] = ~level[g] & prev[g];
		end
	endgenerate

endmodule

//--- timeout_timer.sv
// homing time limit counter in units of ten milliseconds
`timescale 1ns/1ps
module timeout_timer
	import homing_pkg::*;
#(
	parameter int UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// control
	input  wire logic        run,
	input  wire logic [15:0] limit,
	// one-cycle pulse when the limit is reached
	output logic             expired
);

	logic [31:0] prescale;
	logic [15:0] units;
	logic        fired;

	// unit prescaler and unit counter, cleared whenever not running
	always_ff @(posedge mclk) begin
		if (!resetn || !run) begin
			prescale <= 32'h0000_0000;
			units    <= 16'h0000;
		end else if (prescale == 32'(UNIT_CYCLES - 1)) begin
			prescale <= 32'h0000_0000;
			if (units != 16'hFFFF) begin
				units <= units + 16'h0001;
			end
		end else begin
			prescale <= prescale + 32'h0000_0001;
		end
	end

	// single warning pulse per run, a zero limit disables it
	always_ff @(posedge mclk) begin
		if (!resetn || !run) begin
			fired   <= 1'b0;
			expired <= 1'b0;
		end else if (!fired && limit != 16'h0000 && units == limit) begin
			fired   <= 1'b1;
			expired <= 1'b1;
		end else begin
			expired <= 1'b0;
		end
	end

endmodule

//--- homing_sequencer.sv
// homing sequencer with its ahb-lite register file
//
// Overview of operation
// - homing end takes present position as origin
// - calc setting 0 loads feedback with offset
// - calc setting 1 adds offset to feedback
// - high speed and low speed from registers
// - fast toward deceleration point, then slow origin
// - start conditions select the action variant
// - method 8 switch off: fast, rev, fwd, index
// - method 8 switch on: rev slow, fwd, index
// - method 8 limit first: reverse fast, then slow
// - method 9: fast forward, slow forward at edge
// - status bit 12 success, bit 13 error
// - time limit in 10 ms units raises warning
`timescale 1ns/1ps
module homing_sequencer
	import homing_pkg::*;
#(
	parameter int UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// axis sensors and position
	input  wire sense_t      sense,
	input  wire logic [31:0] pos_in,
	// drive command
	output motion_t          motion,
	// interrupt
	output logic             irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [15:0]          control_word;
	logic [7:0]           calc_select;
	logic [7:0]           homing_mode;
	logic [31:0]          home_offset_value;
	logic [31:0]          high_search_speed;
	logic [31:0]          low_search_speed;
	logic [15:0]          timeout_limit;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [31:0]          pos_feedback;
	logic [31:0]          origin_pos;
	logic [31:0]          pos_base;
	logic                 succeeded;
	logic                 failed;
	logic                 timed_out;
	home_state_t          state;
	logic [7:0]           active_mode;
	logic                 fast_fwd;
	logic                 start_prev;
	logic                 dphase_write;
	logic [15:0]          dphase_index;
	logic [2:0]           rise_v;
	logic [2:0]           fall_v;
	logic                 timer_expired;
	logic                 access;
	logic [15:0]          addr_index;
	logic                 start_req;
	logic                 stop_req;
	logic                 running;
	logic                 slow_first_fwd;
	logic                 enter_fault;
	logic [IRQ_WIDTH-1:0] irq_events;
	logic [IRQ_WIDTH-1:0] next_irq_status;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// true for a homing method this sequencer can run
	function automatic logic method_known(input logic [7:0] m);
		return (m == METHOD_REV_FIRST) || (m == METHOD_FWD_FIRST);
	endfunction

	// edges of origin switch, forward limit and index pulse
	edge_detect #(
		.WIDTH(3)
	) u_edges (
		.mclk  (mclk),
		.resetn(resetn),
		.level (sense),
		.rise  (rise_v),
		.fall  (fall_v)
	);

	// homing time limit
	timeout_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_timer (
		.mclk   (mclk),
		.resetn (resetn),
		.run    (running),
		.limit  (timeout_limit),
		.expired(timer_expired)
	);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// accepted address phase and its register index
	assign access     = hsel && hready && htrans[1];
	assign addr_index = haddr[17:2];

	// start and stop from the start bit of the control word
	assign start_req = control_word[CTRL_START_BIT] && !start_prev;
	assign stop_req  = !control_word[CTRL_START_BIT] && start_prev;

	// sequencer is moving the axis
	assign running = (state == ST_FAST) || (state == ST_SLOW_FIRST) ||
	                 (state == ST_SLOW_SECOND) || (state == ST_WAIT_INDEX);

	// first slow leg is reverse for method 8, forward for method 9
	assign slow_first_fwd = (active_mode == METHOD_FWD_FIRST);

	// conditions that end a run with an error
	assign enter_fault = (state inside {ST_IDLE, ST_DONE, ST_FAULT} && start_req && !method_known(homing_mode)) ||
	                     (state == ST_FAST && rise_v[1] && !fast_fwd && !rise_v[2] && !stop_req) ||
	                     ((state == ST_SLOW_FIRST || state == ST_SLOW_SECOND) && rise_v[1] && !stop_req);

	// sticky events, set wins over a read clear
	assign irq_events[IRQ_DONE_BIT]    = (state == ST_LOAD) && !stop_req;
	assign irq_events[IRQ_ERROR_BIT]   = enter_fault;
	assign irq_events[IRQ_TIMEOUT_BIT] = timer_expired;
	assign next_irq_status = ((access && !hwrite && addr_index == IDX_IRQ_STATUS) ? '0 : irq_status) | irq_events;

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	// zero wait state, always okay
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// address phase capture for the write data phase
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dphase_write <= 1'b0;
			dphase_index <= 16'h0000;
		end else if (hready) begin
			dphase_write <= access && hwrite;
			dphase_index <= addr_index;
		end
	end

	// read data registered for the data phase, unmapped reads zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (access && !hwrite) begin
			unique case (addr_index)
				IDX_CONTROL:      hrdata <= {16'h0000, control_word};
				IDX_STATUS:       hrdata <= {16'h0000, 1'b0, timed_out, failed, succeeded, 12'h000};
				IDX_POS_FEEDBACK: hrdata <= pos_feedback;
				IDX_HOME_OFFSET:  hrdata <= home_offset_value;
				IDX_HOMING_MODE:  hrdata <= {24'h00_0000, homing_mode};
				IDX_CALC_SELECT:  hrdata <= {24'h00_0000, calc_select};
				IDX_TIMEOUT:      hrdata <= {16'h0000, timeout_limit};
				IDX_HIGH_SPEED:   hrdata <= high_search_speed;
				IDX_LOW_SPEED:    hrdata <= low_search_speed;
				IDX_IRQ_STATUS:   hrdata <= {29'h0000_0000, irq_status};
				IDX_IRQ_MASK:     hrdata <= {29'h0000_0000, irq_mask};
				default:          hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// writable registers, written in the data phase
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			control_word      <= CONTROL_RESET;
			calc_select       <= CALC_SELECT_RESET;
			homing_mode       <= HOMING_MODE_RESET;
			home_offset_value <= OFFSET_RESET;
			high_search_speed <= SPEED_RESET;
			low_search_speed  <= SPEED_RESET;
			timeout_limit     <= TIMEOUT_RESET;
			irq_mask          <= '0;
		end else if (dphase_write) begin
			unique case (dphase_index)
				IDX_CONTROL:     control_word      <= hwdata[15:0];
				IDX_CALC_SELECT: calc_select       <= hwdata[7:0];
				IDX_HOMING_MODE: homing_mode       <= hwdata[7:0];
				IDX_HOME_OFFSET: home_offset_value <= hwdata;
				IDX_HIGH_SPEED:  high_search_speed <= hwdata;
				IDX_LOW_SPEED:   low_search_speed  <= hwdata;
				IDX_TIMEOUT:     timeout_limit     <= hwdata[15:0];
				IDX_IRQ_MASK:    irq_mask          <= hwdata[IRQ_WIDTH-1:0];
				default:         ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// homing sequencer
	// ----------------------------------------------------------------
	// start bit history for edge detection
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= control_word[CTRL_START_BIT];
		end
	end

	// leg sequencing on switch, limit and index edges
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state       <= ST_IDLE;
			active_mode <= HOMING_MODE_RESET;
			fast_fwd    <= 1'b1;
		end else if (stop_req) begin
			state <= ST_IDLE;
		end else if (enter_fault) begin
			state <= ST_FAULT;
		end else begin
			unique case (state)
				ST_IDLE, ST_DONE, ST_FAULT: begin
					if (start_req) begin
						active_mode <= homing_mode;
						fast_fwd    <= 1'b1;
						// switch already on skips the fast leg
						state <= sense.origin ? ST_SLOW_FIRST : ST_FAST;
					end
				end
				ST_FAST: begin
					if (rise_v[2]) begin
						state <= ST_SLOW_FIRST;
					end else if (rise_v[1]) begin
						fast_fwd <= 1'b0;
					end
				end
				ST_SLOW_FIRST: begin
					if (fall_v[2]) begin
						state <= ST_SLOW_SECOND;
					end
				end
				ST_SLOW_SECOND: begin
					if (rise_v[2]) begin
						state <= ST_WAIT_INDEX;
					end
				end
				ST_WAIT_INDEX: begin
					if (rise_v[0]) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					state <= ST_DONE;
				end
			endcase
		end
	end

	// speed and direction for each leg
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			motion <= '0;
		end else begin
			unique case (state)
				ST_FAST: begin
					motion.run   <= 1'b1;
					motion.fwd   <= fast_fwd;
					motion.speed <= high_search_speed;
				end
				ST_SLOW_FIRST: begin
					motion.run   <= 1'b1;
					motion.fwd   <= slow_first_fwd;
					motion.speed <= low_search_speed;
				end
				ST_SLOW_SECOND, ST_WAIT_INDEX: begin
					motion.run   <= 1'b1;
					motion.fwd   <= !slow_first_fwd;
					motion.speed <= low_search_speed;
				end
				ST_IDLE, ST_LOAD, ST_DONE, ST_FAULT: begin
					motion <= '0;
				end
			endcase
		end
	end

	// result flags, cleared on each new start
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			succeeded <= 1'b0;
			failed    <= 1'b0;
			timed_out <= 1'b0;
		end else begin
			if (state == ST_LOAD && !stop_req) begin
				succeeded <= 1'b1;
			end else if (start_req && !running) begin
				succeeded <= 1'b0;
			end
			if (enter_fault) begin
				failed <= 1'b1;
			end else if (start_req && !running) begin
				failed <= 1'b0;
			end
			if (timer_expired) begin
				timed_out <= 1'b1;
			end else if (start_req && !running) begin
				timed_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// position feedback
	// ----------------------------------------------------------------
	// feedback follows motor travel from the latched origin
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			origin_pos   <= 32'h0000_0000;
			pos_base     <= 32'h0000_0000;
			pos_feedback <= 32'h0000_0000;
		end else begin
			pos_feedback <= pos_base + (pos_in - origin_pos);
			if (state == ST_LOAD && !stop_req) begin
				origin_pos <= pos_in;
				if (calc_select == CALC_WITH_FEEDBACK) begin
					pos_base <= pos_feedback + home_offset_value;
				end else begin
					pos_base <= home_offset_value;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// sticky status and masked level output
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_status <= '0;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

endmodule

//--- homing_chk.sv
// port checker of the homing sequencer
`timescale 1ns/1ps
module homing_chk
	import homing_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        resetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// axis
	input wire sense_t      sense,
	input wire motion_t     motion
);
	// --------------------
	// shadow of speeds and start bit
	// --------------------
	logic        wr_pend;
	logic [15:0] wr_idx;
	logic [31:0] hi_spd;
	logic [31:0] lo_spd;
	logic        go;

	// follow write data phases
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_pend <= 1'b0;
			wr_idx  <= 16'h0000;
			hi_spd  <= SPEED_RESET;
			lo_spd  <= SPEED_RESET;
			go      <= 1'b0;
		end else if (hready) begin
			wr_pend <= hsel & htrans[1] & hwrite;
			wr_idx  <= haddr[17:2];
			if (wr_pend && wr_idx == IDX_HIGH_SPEED)
				hi_spd <= hwdata;
			if (wr_pend && wr_idx == IDX_LOW_SPEED)
				lo_spd <= hwdata;
			if (wr_pend && wr_idx == IDX_CONTROL)
				go <= hwdata[CTRL_START_BIT];
		end
	end

	// --------------------
	// properties
	// --------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// legs of the search
	sequence slow(bit d);
		motion.run && motion.speed == lo_spd && motion.fwd == d;
	endsequence
	sequence fast(bit d);
		motion.run && motion.speed == hi_spd && motion.fwd == d;
	endsequence

	a_bus_okay: assert property ($past(resetn) |-> hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_speed_pair: assert property (motion.run |-> motion.speed == hi_spd || motion.speed == lo_spd)
		else $error("speed is neither search speed");
	a_start_leg: assert property ($rose(motion.run) |-> (fast(1'b1) and !sense.origin) or (sense.origin && motion.speed == lo_spd))
		else $error("wrong first leg");
	a_fast_to_slow: assert property ($past(motion.run) && $past(motion.speed) == hi_spd ##0 motion.run && motion.speed == lo_spd |-> sense.origin)
		else $error("slow leg without origin switch");
	a_limit_turn: assert property ($rose(sense.fwd_limit) ##0 fast(1'b1) |-> ##[1:4] fast(1'b0))
		else $error("no fast reverse at limit");
	a_fall_to_fwd: assert property ($fell(sense.origin) ##0 slow(1'b0) |-> ##[1:4] slow(1'b1))
		else $error("no forward turn at switch fall");
	a_fall_to_rev: assert property ($fell(sense.origin) ##0 slow(1'b1) |-> ##[1:4] slow(1'b0))
		else $error("no reverse turn at switch fall");
	a_idle_zero: assert property (!motion.run |-> motion.speed == 32'h0000_0000)
		else $error("speed without run");
	a_index_stop: assert property ($fell(motion.run) && go |->
		$past(sense.index) && $past(sense.index, 2) && !$past(sense.index, 3))
		else $error("stop away from index");
	a_abort_halt: assert property ($fell(go) |-> ##[1:4] !motion.run)
		else $error("run kept after abort");
endmodule

bind homing_sequencer homing_chk chk (
	.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sense(sense), .motion(motion)
);

//--- axis_model.sv
// axis model: moves on the motion command, makes switch, limit and index
`timescale 1ns/1ps
module axis_model
	import homing_pkg::*;
#(
	parameter int ORG = 1000,
	parameter int WIN = 100,
	parameter int LIM = 1300,
	parameter int IDX = 64
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// command and preset
	input  wire motion_t     motion,
	input  wire logic        load,
	input  wire logic [31:0] load_pos,
	// sensors and position
	output sense_t           sense,
	output logic      [31:0] pos
);
	// --------------------
	// motor
	// --------------------
	logic [2:0] tick;

	// one step each eight cycles, so a stop lands before the next step
	always_ff @(posedge mclk) begin
		if (!resetn)
			tick <= 3'h0;
		else
			tick <= tick + 3'h1;
	end

	// position follows speed and direction
	always_ff @(posedge mclk) begin
		if (!resetn)
			pos <= 32'h0000_0000;
		else if (load)
			pos <= load_pos;
		else if (motion.run && tick == 3'h0)
			pos <= motion.fwd ? pos + motion.speed : pos - motion.speed;
	end

	// switch window, forward limit and index marks
	assign sense.origin    = (int'(pos) >= ORG) && (int'(pos) < ORG + WIN);
	assign sense.fwd_limit = int'(pos) >= LIM;
	assign sense.index     = (int'(pos) % IDX) == 0;
endmodule

//--- homing_sequencer_bench.sv
// self-checking bench of the homing sequencer
`timescale 1ns/1ps
module homing_sequencer_bench
	import homing_pkg::*;
;
	// --------------------
	// signals
	// --------------------
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        load = 1'b0;
	logic [31:0] load_pos = 32'h0;
	logic        hreadyout, hresp, irq;
	logic [31:0] hrdata, pos, rd_val;
	sense_t      sense;
	motion_t     motion;
	int          fail_count = 0;
	int          checks = 0;
	integer      seed;
	string       name_q[$];
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	event        got;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;

	// clock
	always #2.5 mclk = ~mclk;

	// design and axis
	homing_sequencer #(.UNIT_CYCLES(10)) dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense), .pos_in(pos),
		.motion(motion), .irq(irq));
	axis_model axis (.mclk(mclk), .resetn(resetn), .motion(motion), .load(load), .load_pos(load_pos),
		.sense(sense), .pos(pos));

	// --------------------
	// tasks
	// --------------------
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// one single transfer, held until ready
	task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		hsel   <= 1'b1;
		haddr  <= {14'h0, i, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, i, d, x);
	endtask

	// read noted in the queue, judged by the monitor
	task automatic rd(input string n, input logic [15:0] i, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] x;
		name_q.push_back(n);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, i, 32'h0, x);
		rd_val = x;
		->got;
	endtask

	// preset the axis, set up and start a run
	task automatic start(input logic [7:0] m, input logic [7:0] c, input logic [31:0] o, input logic [31:0] p);
		@(posedge mclk);
		load     <= 1'b1;
		load_pos <= p;
		@(posedge mclk);
		load <= 1'b0;
		wr(IDX_HOMING_MODE, {24'h0, m});
		wr(IDX_CALC_SELECT, {24'h0, c});
		wr(IDX_HOME_OFFSET, o);
		wr(IDX_CONTROL, 32'h0);
		wr(IDX_CONTROL, 32'h10);
		repeat (3) @(posedge mclk);
	endtask

	// poll status until success or error
	task automatic home(input logic [7:0] m, input logic [7:0] c, input logic [31:0] o, input logic [31:0] p);
		logic [31:0] s;
		start(m, c, o, p);
		s = 32'h0;
		while (s[13:12] == 2'b00)
			bus(1'b0, IDX_STATUS, 32'h0, s);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// monitor of read results
	always @(got) begin
		cmp(name_q.pop_front(), exp_q.pop_front(), rd_val & msk_q.pop_front());
	end

	// watchdog
	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		final_report;
	end

	// --------------------
	// tests
	// --------------------
	initial begin
		logic [31:0] o1, o2;
		seed = 32'h8255;
		o1 = $random(seed);
		o2 = $random(seed);
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rd("calc", IDX_CALC_SELECT, 32'h0, ALL);
		rd("method", IDX_HOMING_MODE, 32'h8, ALL);
		rd("limit", IDX_TIMEOUT, 32'h64, ALL);
		rd("status", IDX_STATUS, 32'h0, ALL);
		wr(16'h1234, ALL);
		rd("unmapped", 16'h1234, 32'h0, ALL);
		wr(IDX_CALC_SELECT, 32'h1);
		rd("calc", IDX_CALC_SELECT, 32'h1, ALL);
		wr(IDX_TIMEOUT, 32'h0);
		wr(IDX_HIGH_SPEED, 32'h4);
		wr(IDX_LOW_SPEED, 32'h1);
		wr(IDX_IRQ_MASK, 32'h7);
		rd("speed", IDX_HIGH_SPEED, 32'h4, ALL);
		$display("test registers done");
		home(METHOD_REV_FIRST, 8'h00, o1, 32'd0);
		rd("status", IDX_STATUS, 32'h1000, 32'h3000);
		rd("feedback", IDX_POS_FEEDBACK, o1, ALL);
		cmp("position", 32'd1024, pos);
		cmp("irq", 32'h1, {31'h0, irq});
		rd("irq status", IDX_IRQ_STATUS, 32'h1, ALL);
		rd("irq status", IDX_IRQ_STATUS, 32'h0, ALL);
		cmp("irq", 32'h0, {31'h0, irq});
		$display("test switch off done");
		home(METHOD_REV_FIRST, 8'h01, o2, 32'd1024);
		rd("feedback", IDX_POS_FEEDBACK, o1 + o2, ALL);
		$display("test switch on done");
		home(METHOD_REV_FIRST, 8'h00, ~o1, 32'd1200);
		rd("status", IDX_STATUS, 32'h1000, 32'h3000);
		rd("feedback", IDX_POS_FEEDBACK, ~o1, ALL);
		cmp("position", 32'd1024, pos);
		$display("test limit first done");
		home(METHOD_FWD_FIRST, 8'h00, o2, 32'd0);
		rd("feedback", IDX_POS_FEEDBACK, o2, ALL);
		home(8'h03, 8'h00, o1, 32'd0);
		rd("status", IDX_STATUS, 32'h2000, 32'h3000);
		rd("irq status", IDX_IRQ_STATUS, 32'h2, 32'h2);
		$display("test methods done");
		wr(IDX_TIMEOUT, 32'h3);
		home(METHOD_REV_FIRST, 8'h00, o1, 32'd0);
		rd("status", IDX_STATUS, 32'h5000, 32'h7000);
		rd("irq status", IDX_IRQ_STATUS, 32'h4, 32'h4);
		wr(IDX_TIMEOUT, 32'h0);
		start(METHOD_REV_FIRST, 8'h00, o1, 32'd0);
		repeat (20) @(posedge mclk);
		wr(IDX_CONTROL, 32'h0);
		rd("status", IDX_STATUS, 32'h0, 32'h3000);
		cmp("run", 32'h0, {31'h0, motion.run});
		$display("test timeout and abort done");
		final_report;
	end
endmodule
